//--- cint_consts.svh
// register offsets, field positions, reset values and widths of the tuner channel
`ifndef CINT_CONSTS_SVH
`define CINT_CONSTS_SVH

`define CINT_ADDR_W        4
`define CINT_OFF_CTRL      4'h1
`define CINT_OFF_TUNE      4'h2
`define CINT_OFF_FHOLD     4'h3
`define CINT_OFF_POFF      4'h4
`define CINT_OFF_PHOLD     4'h5
`define CINT_OFF_SHIFT     4'h6
`define CINT_OFF_STATUS    4'h7
`define CINT_OFF_FACTOR    4'h8

`define CINT_CTRL_ATT_LSB  0
`define CINT_CTRL_SYNCCLR  2
`define CINT_CTRL_PDITH    3
`define CINT_CTRL_ADITH    4

`define CINT_RST_CTRL      5'h00
`define CINT_RST_TUNE      32'h0000_0000
`define CINT_RST_POFF      16'h0000
`define CINT_RST_HOLD      16'h0000
`define CINT_RST_SHIFT     5'h00
`define CINT_RST_FACTOR    8'h00
`define CINT_RST_LFSR      16'hace1

`define CINT_DATA_W        18
`define CINT_ACC_W         28
`define CINT_ANGLE_W       18
`define CINT_DITH_W        14
`define CINT_SHIFT_MAX     5'h19

`endif

//--- cint_pkg.sv
// types shared by the tuner channel, its source model and its bench
package cint_pkg;
	typedef struct packed {
		logic signed [17:0] i;
		logic signed [17:0] q;
	} cint_iq_s;

	typedef struct packed {
		logic       amp_dither;
		logic       phase_dither;
		logic       sync_clear;
		logic [1:0] atten;
	} cint_ctrl_s;

	typedef struct packed {
		logic                   wr;
		logic                   rd;
		logic [3:0]             addr;
		logic [31:0]            wdata;
	} cint_bus_s;
endpackage

//--- cint_rail.sv
// one rail of the second-order cascaded integrator comb interpolator
`timescale 1ns/1ns
`include "cint_consts.svh"
module cint_rail (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst_sync_n,
	// sample timing
	input  wire logic                      tick,
	input  wire logic                      load,
	// data
	input  wire logic signed [17:0]        din,
	input  wire logic [4:0]                shift,
	output logic signed [17:0]             dout
);
	logic signed [27:0] x1, c1d, integ1, integ2;
	logic signed [27:0] next_x1, next_c1d, next_integ1, next_integ2;
	logic signed [17:0] next_dout;
	logic signed [27:0] c1, c2, stuffed, scaled;

	// combs at the input rate, zero stuffing, then two integrators at the output rate
	always_comb begin
		c1          = 28'(din) - x1;
		c2          = c1 - c1d;
		stuffed     = load ? c2 : 28'sh0;
		next_x1     = x1;
		next_c1d    = c1d;
		next_integ1 = integ1;
		next_integ2 = integ2;
		if (tick) begin
			if (load) begin
				next_x1  = 28'(din);
				next_c1d = c1;
			end
			next_integ1 = integ1 + stuffed;
			next_integ2 = integ2 + integ1 + stuffed;
		end
		// gain of the factor is left in; only the shared shift takes it out
		scaled    = integ2 >>> shift;
		next_dout = scaled[17:0];
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			x1     <= 28'sh0;
			c1d    <= 28'sh0;
			integ1 <= 28'sh0;
			integ2 <= 28'sh0;
			dout   <= 18'sh0;
		end else begin
			x1     <= next_x1;
			c1d    <= next_c1d;
			integ1 <= next_integ1;
			integ2 <= next_integ2;
			dout   <= next_dout;
		end
	end
endmodule

//--- cint_src.sv
// upstream sample source model feeding the tuner channel
`timescale 1ns/1ns
module cint_src
	import cint_pkg::*;
(
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	// control from the bench
	input  wire logic               en,
	input  wire cint_pkg::cint_iq_s level,
	// stream to the tuner
	input  wire logic               in_ready,
	output cint_pkg::cint_iq_s      in_data,
	output logic                    in_valid,
	output int                      gap
);
	int since;

	initial begin
		in_data = '0;
		in_valid = 1'b0;
		gap = 0;
		since = 0;
	end
	// idle data flips each cycle so a stale sample never looks valid
	always @(negedge sys_clk) begin
		in_valid <= en;
		in_data <= en ? level : ~in_data;
	end
	// spacing between take slots, for the rate checks
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			since <= 0;
		end else if (in_ready === 1'b1) begin
			gap <= since + 1;
			since <= 0;
		end else begin
			since <= since + 1;
		end
	end
endmodule

//--- cint_tuner.sv
// per-channel interpolator, oscillator, mixer and control registers
//
// Overview of operation
// - second-stage interpolator is a two-stage integrator comb, triangular response.
// - factor minus one held in an 8-bit register at offset 0x08.
// - interpolator gain equals its factor, not normalized internally.
// - 32-bit quadrature oscillator and mixer shift baseband to the tuned frequency.
// - output is real or complex as the summation block selects.
// - complex mode: oscillator updates every second clock.
// - real mode: oscillator updates every clock, quadrature product dropped.
// - tuning word at 0x02 sets frequency as rate times word over 2^32.
// - control bit 3 enables phase dither.
// - only the top 18 accumulator bits drive angle conversion.
// - control bit 4 enables amplitude dither at mixer input.
// - 16-bit phase offset at 0x04 is added to the accumulator phase.
// - shift amount 0 to 25 at 0x06 attenuates interpolator output.
// - frequency and offset updates deferred by 16-bit hold-off counters.
// - with control bit 2 set, sync clears the oscillator phase.
// - control bits 1:0 give -6, -12, -18 or -24 dB output.
`timescale 1ns/1ns
`include "cint_consts.svh"
module cint_tuner
	import cint_pkg::*;
(
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	// microprocessor port
	input  wire cint_pkg::cint_bus_s       up_bus,
	output logic [31:0]                    up_rdata,
	output logic                           up_rvalid,
	// sync pin and summation mode
	input  wire logic                      sync_pin,
	input  wire logic                      complex_mode,
	// baseband stream from the first stage
	input  wire cint_pkg::cint_iq_s        in_data,
	input  wire logic                      in_valid,
	output logic                           in_ready,
	// tuned stream to the summation block
	output logic signed [17:0]             out_data,
	output logic                           out_valid,
	output logic                           out_is_q
);
	import cint_pkg::*;

	logic [1:0] rst_pipe;
	logic       rst_sync_n;
	logic [2:0] sync_pipe;
	logic       sync_evt;

	cint_ctrl_s ctrl, next_ctrl;
	logic [31:0] tune, tune_sh, next_tune, next_tune_sh;
	logic [15:0] poff, poff_sh, next_poff, next_poff_sh;
	logic [15:0] fhold, phold, next_fhold, next_phold;
	logic [15:0] fcnt, pcnt, next_fcnt, next_pcnt;
	logic [4:0]  shift, next_shift;
	logic [7:0]  factor, next_factor;
	logic [31:0] next_rdata;
	logic        next_rvalid;

	logic [31:0] acc, next_acc;
	logic [15:0] lfsr, next_lfsr;
	logic        half, next_half;
	logic [7:0]  slot, next_slot;
	logic        next_ready;
	logic        tick, load;
	logic signed [16:0] sin_v, cos_v, next_sin, next_cos;
	cint_iq_s    cic_out;
	cint_iq_s    cic_in;
	logic signed [17:0] rail_i_out, rail_q_out;
	logic signed [17:0] next_out;
	logic        next_ovalid, next_isq;

	// reset release through two flops; the first one feeds only the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe[1];

	// sync pin: two synchroniser flops, edge taken between the second and third
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			sync_pipe <= 3'h0;
		else
			sync_pipe <= {sync_pipe[1:0], sync_pin};
	end
	assign sync_evt = sync_pipe[1] & ~sync_pipe[2];

	// register file with shadowed frequency and phase offset
	always_comb begin
		next_ctrl    = ctrl;
		next_tune    = tune;
		next_tune_sh = tune_sh;
		next_poff    = poff;
		next_poff_sh = poff_sh;
		next_fhold   = fhold;
		next_phold   = phold;
		next_fcnt    = fcnt;
		next_pcnt    = pcnt;
		next_shift   = shift;
		next_factor  = factor;
		next_rvalid  = up_bus.rd;
		next_rdata   = 32'h0;
		// hold-off counters run down on the master clock and apply at one
		if (fcnt != 16'h0) begin
			next_fcnt = fcnt - 16'h1;
			if (fcnt == 16'h1)
				next_tune = tune_sh;
		end
		if (pcnt != 16'h0) begin
			next_pcnt = pcnt - 16'h1;
			if (pcnt == 16'h1)
				next_poff = poff_sh;
		end
		if (sync_evt) begin
			if (fhold != 16'h0)
				next_fcnt = fhold;
			if (phold != 16'h0)
				next_pcnt = phold;
		end
		if (up_bus.wr) begin
			case (up_bus.addr)
				`CINT_OFF_CTRL: begin
					next_ctrl = cint_ctrl_s'(up_bus.wdata[4:0]);
				end
				`CINT_OFF_TUNE: begin
					next_tune_sh = up_bus.wdata;
					if (fhold == 16'h0)
						next_tune = up_bus.wdata;
				end
				`CINT_OFF_FHOLD: next_fhold = up_bus.wdata[15:0];
				`CINT_OFF_POFF: begin
					next_poff_sh = up_bus.wdata[15:0];
					if (phold == 16'h0)
						next_poff = up_bus.wdata[15:0];
				end
				`CINT_OFF_PHOLD: next_phold = up_bus.wdata[15:0];
				`CINT_OFF_SHIFT: begin
					// values past the top of the range are clamped to it
					if (up_bus.wdata[4:0] > `CINT_SHIFT_MAX)
						next_shift = `CINT_SHIFT_MAX;
					else
						next_shift = up_bus.wdata[4:0];
				end
				`CINT_OFF_FACTOR: next_factor = up_bus.wdata[7:0];
				default: ;
			endcase
		end
		if (up_bus.rd) begin
			case (up_bus.addr)
				`CINT_OFF_CTRL:   next_rdata = {27'h0, ctrl};
				`CINT_OFF_TUNE:   next_rdata = tune_sh;
				`CINT_OFF_FHOLD:  next_rdata = {16'h0, fhold};
				`CINT_OFF_POFF:   next_rdata = {16'h0, poff_sh};
				`CINT_OFF_PHOLD:  next_rdata = {16'h0, phold};
				`CINT_OFF_SHIFT:  next_rdata = {27'h0, shift};
				`CINT_OFF_STATUS: next_rdata = acc;
				`CINT_OFF_FACTOR: next_rdata = {24'h0, factor};
				default:          next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl      <= cint_ctrl_s'(`CINT_RST_CTRL);
			tune      <= `CINT_RST_TUNE;
			tune_sh   <= `CINT_RST_TUNE;
			poff      <= `CINT_RST_POFF;
			poff_sh   <= `CINT_RST_POFF;
			fhold     <= `CINT_RST_HOLD;
			phold     <= `CINT_RST_HOLD;
			fcnt      <= 16'h0;
			pcnt      <= 16'h0;
			shift     <= `CINT_RST_SHIFT;
			factor    <= `CINT_RST_FACTOR;
			up_rdata  <= 32'h0;
			up_rvalid <= 1'b0;
		end else begin
			ctrl      <= next_ctrl;
			tune      <= next_tune;
			tune_sh   <= next_tune_sh;
			poff      <= next_poff;
			poff_sh   <= next_poff_sh;
			fhold     <= next_fhold;
			phold     <= next_phold;
			fcnt      <= next_fcnt;
			pcnt      <= next_pcnt;
			shift     <= next_shift;
			factor    <= next_factor;
			up_rdata  <= next_rdata;
			up_rvalid <= next_rvalid;
		end
	end

	// update timing: every clock in real mode, every second clock in complex mode
	assign tick = complex_mode ? half : 1'b1;
	assign load = tick && (slot == 8'h0);
	assign cic_in = (load && in_valid) ? in_data : cint_iq_s'(36'h0);

	// oscillator datapath
	logic [31:0] phase;
	logic [17:0] angle, angle_c;
	logic [16:0] ys, yc;
	logic [33:0] ps, pc;
	logic [16:0] ms, mc;
	logic        ad;

	always_comb begin
		next_half  = complex_mode ? ~half : 1'b1;
		next_slot  = slot;
		if (tick)
			next_slot = (slot == factor) ? 8'h0 : slot + 8'h1;
		// ready must coincide with the load slot, i.e. the next tick
		next_ready = (complex_mode ? next_half : 1'b1) && (next_slot == 8'h0);
		next_lfsr  = {lfsr[14:0], lfsr[15] ^ lfsr[14] ^ lfsr[12] ^ lfsr[3]};
		next_acc   = acc;
		if (sync_evt && ctrl.sync_clear)
			next_acc = 32'h0;
		else if (tick)
			next_acc = acc + tune;
		phase = acc + {poff, 16'h0};
		if (ctrl.phase_dither)
			phase = phase + {18'h0, lfsr[`CINT_DITH_W-1:0]};
		angle   = phase[31:14];
		angle_c = angle + 18'h10000;
		// parabolic half-wave sine: cheap, trades purity for area
		ys = angle[16:0];
		yc = angle_c[16:0];
		ps = 34'(ys) * 34'(18'h20000 - {1'b0, ys});
		pc = 34'(yc) * 34'(18'h20000 - {1'b0, yc});
		ad = ctrl.amp_dither & lfsr[15];
		ms = 17'(({1'b0, ps[33:17]} + {17'h0, ad}) >> 1);
		mc = 17'(({1'b0, pc[33:17]} + {17'h0, ad}) >> 1);
		next_sin = angle[17] ? -$signed(ms) : $signed(ms);
		next_cos = angle_c[17] ? -$signed(mc) : $signed(mc);
		if (!tick) begin
			next_sin = sin_v;
			next_cos = cos_v;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			half     <= 1'b1;
			slot     <= 8'h0;
			in_ready <= 1'b0;
			lfsr     <= `CINT_RST_LFSR;
			acc      <= 32'h0;
			sin_v    <= 17'sh0;
			cos_v    <= 17'sh0;
		end else begin
			half     <= next_half;
			slot     <= next_slot;
			in_ready <= next_ready;
			lfsr     <= next_lfsr;
			acc      <= next_acc;
			sin_v    <= next_sin;
			cos_v    <= next_cos;
		end
	end

	cint_rail rail_i (
		.sys_clk    (sys_clk),
		.rst_sync_n (rst_sync_n),
		.tick       (tick),
		.load       (load),
		.din        (cic_in.i),
		.shift      (shift),
		.dout       (rail_i_out)
	);

	cint_rail rail_q (
		.sys_clk    (sys_clk),
		.rst_sync_n (rst_sync_n),
		.tick       (tick),
		.load       (load),
		.din        (cic_in.q),
		.shift      (shift),
		.dout       (rail_q_out)
	);
	assign cic_out = {rail_i_out, rail_q_out};

	// quadrature mixer; output loses 6 dB per attenuation step plus the fixed 6 dB
	logic signed [35:0] re_p, im_p, scaled;
	always_comb begin
		re_p = 36'(cic_out.i * cos_v) - 36'(cic_out.q * sin_v);
		im_p = 36'(cic_out.i * sin_v) + 36'(cic_out.q * cos_v);
		next_isq = complex_mode & half;
		scaled = (next_isq ? im_p : re_p) >>> (6'd15 + 6'(ctrl.atten));
		next_out = scaled[17:0];
		next_ovalid = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			out_data  <= 18'sh0;
			out_valid <= 1'b0;
			out_is_q  <= 1'b0;
		end else begin
			out_data  <= next_out;
			out_valid <= next_ovalid;
			out_is_q  <= next_isq;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_sync_n);

	a_acc_step_real: assert property (!complex_mode && !sync_evt |=> acc == $past(acc) + $past(tune)) else $error("acc step wrong");
	a_acc_hold_cplx: assert property (complex_mode && !tick && !sync_evt |=> acc == $past(acc)) else $error("acc moved off tick");
	a_sync_clear: assert property (sync_evt && ctrl.sync_clear |=> acc == 32'h0) else $error("sync clear missed");
	a_sync_keep: assert property (sync_evt && !ctrl.sync_clear && tick |=> acc == $past(acc) + $past(tune)) else $error("sync cleared acc");
	a_tune_direct: assert property (up_bus.wr && up_bus.addr == `CINT_OFF_TUNE && fhold == 16'h0 |=> tune == $past(up_bus.wdata)) else $error("tune write lost");
	a_hold_defer: assert property (fcnt == 16'h2 |=> fcnt == 16'h1 ##1 tune == $past(tune_sh)) else $error("holdoff apply wrong");
	a_shift_range: assert property (shift <= `CINT_SHIFT_MAX) else $error("shift out of range");
	a_factor_write: assert property (up_bus.wr && up_bus.addr == `CINT_OFF_FACTOR |=> factor == $past(up_bus.wdata[7:0])) else $error("factor write lost");
	a_load_spacing: assert property (load && !complex_mode && factor == 8'h2 && $past(factor) == 8'h2 |=> !load ##1 !load) else $error("load spacing wrong");
	a_real_no_q: assert property (!complex_mode |=> !out_is_q) else $error("q in real mode");
	a_cplx_alt: assert property (complex_mode && $past(complex_mode) |=> out_is_q != $past(out_is_q)) else $error("iq not alternating");
	a_ctrl_write: assert property (up_bus.wr && up_bus.addr == `CINT_OFF_CTRL |=> ctrl.phase_dither == $past(up_bus.wdata[3]) && ctrl.amp_dither == $past(up_bus.wdata[4])) else $error("ctrl write lost");

	c_sync_clear: cover property (sync_evt && ctrl.sync_clear);
	c_holdoff_apply: cover property (fcnt == 16'h1);
	c_complex_run: cover property (complex_mode && load && in_valid);
	c_read_status: cover property (up_bus.rd && up_bus.addr == `CINT_OFF_STATUS);
endmodule

//--- cint_tuner_tb.sv
// self-checking bench for the tuner channel
`timescale 1ns/1ns
`include "cint_consts.svh"
module cint_tuner_tb;
	import cint_pkg::*;
	logic               sys_clk, rst_n, sync_pin, complex_mode, en, q0;
	logic               up_rvalid, in_valid, in_ready, out_valid, out_is_q;
	cint_bus_s          bus;
	cint_iq_s           level, in_data;
	logic [31:0]        up_rdata, d1, d2, w;
	logic signed [17:0] out_data;
	logic [15:0]        seed;
	int                 mismatches, check_count, cyc, gap, t1, t2, c, f, s;
	logic [3:0]         wa [5] = '{`CINT_OFF_TUNE, `CINT_OFF_POFF, `CINT_OFF_FACTOR,
		`CINT_OFF_CTRL, 4'h9};
	logic [31:0]        wm [5] = '{32'hffff_ffff, 32'h0000_ffff, 32'h0000_00ff,
		32'h0000_001f, 32'h0};

	cint_tuner dut (.sys_clk(sys_clk), .rst_n(rst_n), .up_bus(bus), .up_rdata(up_rdata),
		.up_rvalid(up_rvalid), .sync_pin(sync_pin), .complex_mode(complex_mode),
		.in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
		.out_valid(out_valid), .out_is_q(out_is_q));
	cint_src src (.sys_clk(sys_clk), .rst_n(rst_n), .en(en), .level(level),
		.in_ready(in_ready), .in_data(in_data), .in_valid(in_valid), .gap(gap));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction
	// steady dc through interpolator gain, shift, cosine peak and output attenuation
	function automatic logic signed [17:0] exp_dc(input int c, l, s, att, input bit flip);
		longint v;
		v = (longint'(c) * l) >>> s;
		v = v * (flip ? -16384 : 16384);
		return 18'(v >>> (15 + att));
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus.wr = 1'b1;
		bus.addr = a;
		bus.wdata = d;
		@(negedge sys_clk);
		bus.wr = 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output int t);
		int n;
		n = 0;
		bus.rd = 1'b1;
		bus.addr = a;
		t = cyc;
		@(negedge sys_clk);
		bus.rd = 1'b0;
		while (up_rvalid !== 1'b1 && n < 4) begin
			@(negedge sys_clk);
			n++;
		end
		d = up_rdata;
		chk("read answer", 32'h1, {31'h0, up_rvalid});
		@(negedge sys_clk);
	endtask
	// two status reads ten cycles apart
	task automatic acc_step(output logic [31:0] dd, output int sp);
		logic [31:0] a0, a1;
		int ta, tb;
		rd(`CINT_OFF_STATUS, a0, ta);
		repeat (8) @(negedge sys_clk);
		rd(`CINT_OFF_STATUS, a1, tb);
		dd = a1 - a0;
		sp = tb - ta;
	endtask
	task automatic pulse();
		sync_pin = 1'b1;
		repeat (4) @(negedge sys_clk);
		sync_pin = 1'b0;
		repeat (6) @(negedge sys_clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial begin
		bus = '0;
		level = '0;
		sync_pin = 1'b0;
		complex_mode = 1'b0;
		en = 1'b0;
		seed = 16'ha935;
		rst_n = 1'b0;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		for (int a = 1; a <= 9; a++) begin
			rd(4'(a), d1, t1);
			chk("reset value", 32'h0, d1);
		end
		w = {rnd(), rnd()};
		foreach (wa[k]) begin
			wr(wa[k], w);
			rd(wa[k], d1, t1);
			chk("register readback", w & wm[k], d1);
		end
		wr(`CINT_OFF_SHIFT, 32'h1f);
		rd(`CINT_OFF_SHIFT, d1, t1);
		chk("shift clamp", 32'h19, d1);
		$display("test 1 done: register access");
		wr(`CINT_OFF_CTRL, 32'h0);
		wr(`CINT_OFF_POFF, 32'h0);
		for (int m = 0; m < 2; m++) begin
			complex_mode = m[0];
			acc_step(d2, t2);
			chk("phase step", w * 32'(t2 >> m), d2);
		end
		complex_mode = 1'b0;
		$display("test 2 done: accumulator rate");
		wr(`CINT_OFF_TUNE, 32'h0);
		rd(`CINT_OFF_STATUS, d1, t1);
		pulse();
		rd(`CINT_OFF_STATUS, d2, t2);
		chk("phase kept", d1, d2);
		wr(`CINT_OFF_CTRL, 32'h4);
		pulse();
		rd(`CINT_OFF_STATUS, d2, t2);
		chk("phase cleared", 32'h0, d2);
		$display("test 3 done: sync clear");
		wr(`CINT_OFF_FHOLD, 32'd20);
		wr(`CINT_OFF_TUNE, w);
		acc_step(d2, t2);
		chk("held frequency", 32'h0, d2);
		pulse();
		repeat (20) @(negedge sys_clk);
		acc_step(d2, t2);
		chk("released frequency", w * 32'(t2), d2);
		wr(`CINT_OFF_FHOLD, 32'h0);
		wr(`CINT_OFF_TUNE, 32'h0);
		pulse();
		$display("test 4 done: frequency hold-off");
		for (int i = 0; i < 8; i++) begin
			// corner factors first, then random ones
			f = (i == 0) ? 2 : (i == 1) ? 0 : int'(rnd() % 8); // below first-stage limit
			s = int'(rnd() % 4);
			c = int'($signed(rnd())) >>> 4;
			level.i = 18'(c);
			level.q = 18'($signed(rnd()));
			// integrators keep old steps, so restart them before a new factor
			en = 1'b0;
			rst_n = 1'b0;
			repeat (2) @(negedge sys_clk);
			rst_n = 1'b1;
			repeat (4) @(negedge sys_clk);
			wr(`CINT_OFF_FACTOR, 32'(f));
			wr(`CINT_OFF_SHIFT, 32'(s));
			wr(`CINT_OFF_POFF, i < 4 ? 32'h0 : 32'h8000);
			wr(`CINT_OFF_CTRL, 32'(4 + i % 4));
			en = 1'b1;
			repeat (60) @(negedge sys_clk);
			chk("sample spacing", 32'(f + 1), 32'(gap));
			chk("stream flags", 32'h2, {30'h0, out_valid, out_is_q});
			chk("dc output", 32'(exp_dc(c, f + 1, s, i % 4, i >= 4)), 32'(out_data));
		end
		$display("test 5 done: gain, offset and attenuation");
		complex_mode = 1'b1;
		repeat (40) @(negedge sys_clk);
		chk("complex spacing", 32'(2 * (f + 1)), 32'(gap));
		q0 = out_is_q;
		@(negedge sys_clk);
		chk("quadrature flag", {31'h0, ~q0}, {31'h0, out_is_q});
		$display("test 6 done: complex output");
		tally_and_finish();
	end
endmodule
